/* File: rtl/rcso_pkg.sv */
// Constants and carrier types for reset cause and system options
package rcso_pkg;

   // ***********************************************
   // Register field positions
   // ***********************************************
   localparam int RCSO_CAUSE_POR = 7;
   localparam int RCSO_CAUSE_PIN = 6;
   localparam int RCSO_CAUSE_WDOG = 5;
   localparam int RCSO_CAUSE_ILLEGAL_OP_CAUSE = 4;
   localparam int RCSO_CAUSE_CLKGEN = 2;
   localparam int RCSO_CAUSE_LV = 1;
   localparam int RCSO_OPT_WDOG_EN = 7;
   localparam int RCSO_OPT_WDOG_LONG = 6;
   localparam int RCSO_OPT_STOP_ALLOW = 5;
   localparam int RCSO_OPT_DBG_PIN = 1;
   localparam int RCSO_OPT_RST_PIN = 0;
   localparam int RCSO_OPT2_CLK_SEL = 7;
   localparam int RCSO_DBG_FORCE = 0;

   // ***********************************************
   // Reset values
   // ***********************************************
   localparam logic [7:0] RCSO_CAUSE_POR_VAL = 8'h82;
   localparam logic RCSO_WDOG_EN_RST = 1'b1;
   localparam logic RCSO_WDOG_LONG_RST = 1'b1;
   localparam logic RCSO_STOP_ALLOW_RST = 1'b0;
   localparam logic RCSO_DBG_PIN_RST = 1'b1;
   localparam logic RCSO_RST_PIN_POR = 1'b0;
   localparam logic RCSO_CLK_SEL_RST = 1'b1;
   localparam logic [7:0] RCSO_ZERO_BYTE = 8'h00;

   // ***********************************************
   // Timing counts
   // ***********************************************
   localparam int RCSO_HOLD_W = 5;
   localparam logic [RCSO_HOLD_W-1:0] RCSO_RESET_HOLD_CYC = 5'h10;
   localparam int RCSO_WDOG_W = 18;
   localparam int RCSO_WDOG_SHORT_BUS = 8192;
   localparam int RCSO_WDOG_LONG_BUS = 131072;
   localparam int RCSO_WDOG_SHORT_TICK = 32;
   localparam int RCSO_WDOG_LONG_TICK = 256;

   // ***********************************************
   // Types
   // ***********************************************
   typedef enum logic [1:0] {
      RCSO_SEL_CAUSE,
      RCSO_SEL_DBG,
      RCSO_SEL_OPT1,
      RCSO_SEL_OPT2
   } rcso_sel_e;

   typedef struct packed {
      logic rd;
      logic wr;
      logic bg;
      rcso_sel_e sel;
      logic [7:0] wdata;
   } rcso_req_s;

   typedef struct packed {
      logic watchdog_enable;
      logic watchdog_long_timeout;
      logic stop_allow;
      logic debug_pin_enable;
      logic reset_pin_enable;
      logic watchdog_clk_sel;
   } rcso_opt_s;

   typedef struct packed {
      logic pin;
      logic wdog;
      logic illegal_op_cause;
      logic clkgen;
      logic lv;
      logic dbg;
   } rcso_evt_s;

endpackage

/* File: rtl/rcso_wdog.sv */
// Watchdog counter with restart and selectable time base
module rcso_wdog
   import rcso_pkg::*;
#(
   parameter int SHORT_BUS = RCSO_WDOG_SHORT_BUS,
   parameter int LONG_BUS = RCSO_WDOG_LONG_BUS
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic restart_i,
   input wire logic enable_i,
   input wire logic long_i,
   input wire logic clk_sel_i,
   input wire logic tick_i,
   output logic timeout_o
);

   typedef struct packed {
      logic [RCSO_WDOG_W-1:0] count;
      logic timeout;
   } rcso_wdog_s;

   rcso_wdog_s st;
   rcso_wdog_s next_st;
   logic [RCSO_WDOG_W-1:0] limit;
   logic step;

   always_comb begin
      next_st = st;
      next_st.timeout = 1'b0;
      if (clk_sel_i) begin
         step = tick_i;
         limit = long_i ? RCSO_WDOG_W'(RCSO_WDOG_LONG_TICK - 1)
                        : RCSO_WDOG_W'(RCSO_WDOG_SHORT_TICK - 1);
      end else begin
         step = 1'b1;
         limit = long_i ? RCSO_WDOG_W'(LONG_BUS - 1) : RCSO_WDOG_W'(SHORT_BUS - 1);
      end
      // Disabled watchdog never times out
      if (restart_i || !enable_i) begin
         next_st.count = '0;
      end else if (step) begin
         if (st.count >= limit) begin
            next_st.count = '0;
            next_st.timeout = 1'b1;
         end else begin
            next_st.count = st.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign timeout_o = st.timeout;

endmodule

/* File: rtl/rcso_top.sv */
// Reset cause recorder, debug forced reset and write-once system options

// Behaviour
// R01: Read-only cause register: bits 7,6,5,4,2,1 are flags; bits 3,0 read zero.
// R02: A debug forced reset leaves every cause flag cleared.
// R03: Any write to the cause register restarts the watchdog; flags keep value.
// R04: Power-on reset sets power-on and low-voltage flags, clears the rest.
// R05: Low-voltage reset sets its flag, clears others, keeps power-on flag.
// R06: On reset, flags of active sources set, flags of inactive sources cleared.
// R07: Pin flag at bit 6 marks a reset from low reset pin level.
// R08: Watchdog flag at bit 5 on timeout; no watchdog reset when disabled.
// R09: Illegal flag on bad opcode, disallowed stop or disabled background op.
// R10: Clock generator flag at bit 2 on clock generator reset request.
// R11: Low-voltage reset needs both enables and trip; off in stop unless enabled.
// R12: Background write of 1 to bit 0 of debug register forces reset.
// R13: User program writes to the debug register are ignored.
// R14: Debug register always reads zero.
// R15: Options register takes only first write after reset; reads always allowed.
// R16: Options bits 3 and 2 read zero.
// R17: Watchdog enable at bit 7 resets to 1; 0 disables watchdog.
// R18: Bit 6 picks short or long watchdog period with clock select.
// R19: Stop allow at bit 5 resets to 0; stop then gives illegal reset.
// R20: Debug pin enable at bit 1 resets to debug function after any reset.
// R21: Reset pin enable at bit 0 cleared by power-on only; set adds pull-up.
// R22: Software should write options once at start so they become locked.
// R23: Every reset source clears the options write lock.
// R24: Watchdog clock select picks 1-kHz tick or bus clock; write-once.
module rcso_top
   import rcso_pkg::*;
#(
   parameter int WDOG_SHORT_BUS = RCSO_WDOG_SHORT_BUS,
   parameter int WDOG_LONG_BUS = RCSO_WDOG_LONG_BUS
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire rcso_req_s req_i,
   input wire logic reset_pin_i,
   input wire logic lv_trip_i,
   input wire logic lv_detect_enable_i,
   input wire logic lv_reset_enable_i,
   input wire logic lv_stop_enable_i,
   input wire logic in_stop_i,
   input wire logic unimpl_opcode_i,
   input wire logic stop_instr_i,
   input wire logic bg_instruction_i,
   input wire logic bg_mode_enable_i,
   input wire logic clockgen_reset_req_i,
   input wire logic wdog_tick_i,
   output logic [7:0] rdata_o,
   output logic system_reset_o,
   output logic stop_grant_o,
   output rcso_opt_s opt_o,
   output logic [7:0] cause_o
);

   // ***********************************************
   // State
   // ***********************************************
   typedef enum logic {
      RCSO_RUN,
      RCSO_HOLD
   } rcso_phase_e;

   typedef struct packed {
      rcso_phase_e phase;
      logic [RCSO_HOLD_W-1:0] hold_cnt;
      logic [7:0] cause;
      rcso_opt_s opt;
      logic opt1_locked;
      logic opt2_locked;
      logic [7:0] rdata;
      logic [2:0] pin_sync;
      logic pin_level;
      logic [2:0] lv_sync;
      logic lv_level;
   } rcso_state_s;

   rcso_state_s st;
   rcso_state_s next_st;
   rcso_evt_s evt;
   logic wdog_timeout;
   logic wdog_restart;
   logic lv_armed;
   logic any_evt;
   logic cpu_ok;

   // ***********************************************
   // Helpers
   // ***********************************************
   function automatic logic [2:0] rcso_shift(input logic [2:0] s, input logic d);
      rcso_shift = {s[1:0], d};
   endfunction

   // Level changes only once second and third stage agree
   function automatic logic rcso_filter(input logic [2:0] s, input logic prev);
      rcso_filter = (s[1] == s[2]) ? s[2] : prev;
   endfunction

   function automatic logic [7:0] rcso_cause_byte(input rcso_evt_s e,
                                                   input logic por_prev);
      logic [7:0] c;
      c = RCSO_ZERO_BYTE;
      if (!e.dbg) begin
         c[RCSO_CAUSE_PIN] = e.pin; // R07
         c[RCSO_CAUSE_WDOG] = e.wdog; // R08
         c[RCSO_CAUSE_ILLEGAL_OP_CAUSE] = e.illegal_op_cause; // R09
         c[RCSO_CAUSE_CLKGEN] = e.clkgen; // R10
         c[RCSO_CAUSE_LV] = e.lv; // R05
         c[RCSO_CAUSE_POR] = e.lv & por_prev; // R05
      end
      rcso_cause_byte = c;
   endfunction

   function automatic logic [7:0] rcso_opt1_byte(input rcso_opt_s o);
      logic [7:0] b;
      b = RCSO_ZERO_BYTE;
      b[RCSO_OPT_WDOG_EN] = o.watchdog_enable;
      b[RCSO_OPT_WDOG_LONG] = o.watchdog_long_timeout;
      b[RCSO_OPT_STOP_ALLOW] = o.stop_allow;
      b[RCSO_OPT_DBG_PIN] = o.debug_pin_enable;
      b[RCSO_OPT_RST_PIN] = o.reset_pin_enable;
      rcso_opt1_byte = b;
   endfunction

   // Write strobe aimed at one register
   function automatic logic rcso_wr_hit(input rcso_req_s r, input rcso_sel_e s);
      rcso_wr_hit = r.wr && (r.sel == s);
   endfunction

   function automatic logic [7:0] rcso_read_byte(input rcso_sel_e s, input logic [7:0] cause,
                                                 input rcso_opt_s o);
      logic [7:0] b;
      b = RCSO_ZERO_BYTE;
      unique case (s)
         RCSO_SEL_CAUSE: begin
            b = cause; // R01
         end
         RCSO_SEL_DBG: begin
            b = RCSO_ZERO_BYTE; // R14
         end
         RCSO_SEL_OPT1: begin
            b = rcso_opt1_byte(o); // R15 R16
         end
         RCSO_SEL_OPT2: begin
            b[RCSO_OPT2_CLK_SEL] = o.watchdog_clk_sel; // R24
         end
      endcase
      rcso_read_byte = b;
   endfunction

   // Internal resets restore defaults; the reset pin choice survives them
   function automatic rcso_opt_s rcso_opt_defaults(input rcso_opt_s o);
      rcso_opt_s d;
      d = o;
      d.watchdog_enable = RCSO_WDOG_EN_RST; // R17
      d.watchdog_long_timeout = RCSO_WDOG_LONG_RST;
      d.stop_allow = RCSO_STOP_ALLOW_RST; // R19
      d.debug_pin_enable = RCSO_DBG_PIN_RST; // R20
      d.watchdog_clk_sel = RCSO_CLK_SEL_RST;
      rcso_opt_defaults = d;
   endfunction

   function automatic rcso_opt_s rcso_opt1_write(input rcso_opt_s o, input logic [7:0] w);
      rcso_opt_s n;
      n = o;
      n.watchdog_enable = w[RCSO_OPT_WDOG_EN];
      n.watchdog_long_timeout = w[RCSO_OPT_WDOG_LONG];
      n.stop_allow = w[RCSO_OPT_STOP_ALLOW];
      n.debug_pin_enable = w[RCSO_OPT_DBG_PIN];
      // Once set, only power-on clears it
      n.reset_pin_enable = o.reset_pin_enable | w[RCSO_OPT_RST_PIN]; // R21
      rcso_opt1_write = n;
   endfunction

   // ***********************************************
   // Watchdog
   // ***********************************************
   rcso_wdog #(
      .SHORT_BUS(WDOG_SHORT_BUS),
      .LONG_BUS(WDOG_LONG_BUS)
   ) u_wdog (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .restart_i(wdog_restart),
      .enable_i(st.opt.watchdog_enable), // R17
      .long_i(st.opt.watchdog_long_timeout), // R18
      .clk_sel_i(st.opt.watchdog_clk_sel), // R24
      .tick_i(wdog_tick_i),
      .timeout_o(wdog_timeout)
   );

   // ***********************************************
   // Reset sources
   // ***********************************************
   always_comb begin
      cpu_ok = (st.phase == RCSO_RUN);
      // Detector is off in stop unless kept alive
      lv_armed = lv_detect_enable_i & lv_reset_enable_i
                 & (!in_stop_i | lv_stop_enable_i); // R11
      evt.pin = st.opt.reset_pin_enable & !st.pin_level; // R07
      evt.wdog = wdog_timeout & st.opt.watchdog_enable; // R08
      evt.illegal_op_cause = unimpl_opcode_i
                 | (stop_instr_i & !st.opt.stop_allow) // R19
                 | (bg_instruction_i & !bg_mode_enable_i); // R09
      evt.clkgen = clockgen_reset_req_i; // R10
      evt.lv = lv_armed & st.lv_level; // R11
      // Only a background access may reach the force bit
      evt.dbg = rcso_wr_hit(req_i, RCSO_SEL_DBG) & req_i.bg
                & req_i.wdata[RCSO_DBG_FORCE]; // R12 R13
      any_evt = cpu_ok & (|evt);
      wdog_restart = (cpu_ok & rcso_wr_hit(req_i, RCSO_SEL_CAUSE)) // R03
                     | !cpu_ok;
   end

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      next_st = st;
      next_st.pin_sync = rcso_shift(st.pin_sync, reset_pin_i);
      next_st.pin_level = rcso_filter(st.pin_sync, st.pin_level);
      next_st.lv_sync = rcso_shift(st.lv_sync, lv_trip_i);
      next_st.lv_level = rcso_filter(st.lv_sync, st.lv_level);
      unique case (st.phase)
         RCSO_RUN: begin
            if (any_evt) begin
               // Active sources set, inactive cleared
               next_st.cause = rcso_cause_byte(evt, st.cause[RCSO_CAUSE_POR]); // R06 R02
               next_st.phase = RCSO_HOLD;
               next_st.hold_cnt = '0;
               next_st.rdata = RCSO_ZERO_BYTE;
               next_st.opt = rcso_opt_defaults(st.opt); // R17 R19 R20 R21
               next_st.opt1_locked = 1'b0; // R23
               next_st.opt2_locked = 1'b0; // R23
            end else begin
               if (req_i.rd) begin
                  next_st.rdata = rcso_read_byte(req_i.sel, st.cause, st.opt); // R01 R14
               end
               if (rcso_wr_hit(req_i, RCSO_SEL_OPT1) && !st.opt1_locked) begin
                  next_st.opt1_locked = 1'b1; // R15
                  next_st.opt = rcso_opt1_write(st.opt, req_i.wdata);
               end
               // Clock select keeps a lock of its own, apart from the other options
               if (rcso_wr_hit(req_i, RCSO_SEL_OPT2) && !st.opt2_locked) begin
                  next_st.opt2_locked = 1'b1; // R24
                  next_st.opt.watchdog_clk_sel = req_i.wdata[RCSO_OPT2_CLK_SEL];
               end
            end
         end
         RCSO_HOLD: begin
            // CPU is held in reset, so its requests are dropped
            next_st.hold_cnt = st.hold_cnt + 1'b1;
            if (st.hold_cnt == RCSO_RESET_HOLD_CYC - 1'b1) begin
               next_st.phase = RCSO_RUN;
               next_st.hold_cnt = '0;
            end
         end
      endcase
   end

   // ***********************************************
   // Registers
   // ***********************************************
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         st.phase <= RCSO_HOLD;
         st.hold_cnt <= '0;
         st.cause <= RCSO_CAUSE_POR_VAL; // R04
         st.opt.watchdog_enable <= RCSO_WDOG_EN_RST;
         st.opt.watchdog_long_timeout <= RCSO_WDOG_LONG_RST;
         st.opt.stop_allow <= RCSO_STOP_ALLOW_RST;
         st.opt.debug_pin_enable <= RCSO_DBG_PIN_RST;
         st.opt.reset_pin_enable <= RCSO_RST_PIN_POR; // R21
         st.opt.watchdog_clk_sel <= RCSO_CLK_SEL_RST;
         st.opt1_locked <= 1'b0;
         st.opt2_locked <= 1'b0;
         st.rdata <= RCSO_ZERO_BYTE;
         st.pin_sync <= 3'b111;
         st.pin_level <= 1'b1;
         st.lv_sync <= 3'b000;
         st.lv_level <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ***********************************************
   // Outputs
   // ***********************************************
   assign rdata_o = st.rdata;
   assign system_reset_o = (st.phase == RCSO_HOLD);
   assign stop_grant_o = cpu_ok & stop_instr_i & st.opt.stop_allow; // R19
   assign opt_o = st.opt;
   assign cause_o = st.cause;

endmodule

/* File: tb/rcso_asserts.sv */
// Concurrent checks on the reset cause and options block ports
module rcso_asserts
   import rcso_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_i,
   input wire rcso_req_s req_i,
   input wire logic unimpl_opcode_i,
   input wire logic stop_instr_i,
   input wire logic [7:0] rdata_o,
   input wire logic system_reset_o,
   input wire logic stop_grant_o,
   input wire rcso_opt_s opt_o,
   input wire logic [7:0] cause_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ***********************************************
   // Helpers
   // ***********************************************
   logic run;
   logic force_w;
   logic locked;
   assign run = !system_reset_o;
   assign force_w = req_i.wr && req_i.bg && req_i.sel == RCSO_SEL_DBG && req_i.wdata[0];

   // Clock select has its own lock, so only the first five fields are watched
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         locked <= 1'b0;
      end else if (system_reset_o) begin
         locked <= 1'b0;
      end else if (req_i.wr && req_i.sel == RCSO_SEL_OPT1) begin
         locked <= 1'b1;
      end
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (reset_i);

   sequence s_fault;
      run && (unimpl_opcode_i || stop_instr_i && !opt_o.stop_allow) && !force_w;
   endsequence
   sequence s_hold;
      system_reset_o [*8] ##1 system_reset_o [*8] ##1 !system_reset_o;
   endsequence

   // ***********************************************
   // Properties
   // ***********************************************
   cause_gaps_a: assert property (cause_o[3] == 1'b0 && cause_o[0] == 1'b0)
      else $error("cause bits 3 or 0 set");
   cause_read_a: assert property (run && req_i.rd && req_i.sel == RCSO_SEL_CAUSE
      |=> system_reset_o || rdata_o == $past(cause_o)) else $error("cause read wrong");
   dbg_read_zero_a: assert property (run && req_i.rd && req_i.sel == RCSO_SEL_DBG
      |=> rdata_o == 8'h00) else $error("debug register read not zero");
   illegal_op_a: assert property (s_fault |=> system_reset_o && cause_o[4])
      else $error("illegal op reset missing");
   debug_force_a: assert property (run && force_w |=> system_reset_o && cause_o == 8'h00)
      else $error("debug force reset wrong");
   user_dbg_a: assert property (run && req_i.wr && !req_i.bg && req_i.sel == RCSO_SEL_DBG
      |=> !(system_reset_o && cause_o == 8'h00)) else $error("user debug write acted");
   hold_len_a: assert property ($rose(system_reset_o) |-> s_hold)
      else $error("reset hold length wrong");
   opt_lock_a: assert property (locked && run && req_i.wr && req_i.sel == RCSO_SEL_OPT1
      |=> system_reset_o || $stable(opt_o[5:1])) else $error("second options write took");
   stop_gate_a: assert property (stop_grant_o == (stop_instr_i && opt_o.stop_allow && run))
      else $error("stop grant wrong");
   wdog_off_a: assert property ($rose(system_reset_o) && !$past(opt_o.watchdog_enable)
      |-> !cause_o[5]) else $error("watchdog reset while disabled");
endmodule

bind rcso_top rcso_asserts u_chk (.clock_i, .reset_i, .req_i, .unimpl_opcode_i,
   .stop_instr_i, .rdata_o, .system_reset_o, .stop_grant_o, .opt_o, .cause_o);

/* File: tb/rcso_host.sv */
// Bus and background debug host model driving register requests
module rcso_host
   import rcso_pkg::*;
(
   input wire logic clock_i,
   output rcso_req_s req_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req_o = '0;

   // Strobes live one cycle; released data is inverted so a stale byte never looks valid
   task automatic access(input logic rd, input logic wr, input logic bg, input rcso_sel_e sel,
                         input logic [7:0] data);
      @(negedge clock_i);
      req_o <= '{rd, wr, bg, sel, data};
      @(negedge clock_i);
      req_o <= '{1'b0, 1'b0, 1'b0, sel, ~data};
   endtask
endmodule

/* File: tb/rcso_top_tb.sv */
// Self-checking bench for the reset cause and system options block
module rcso_top_tb
   import rcso_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock_i = 0, reset_i = 1, idle = 0;
   rcso_req_s req_i;
   logic reset_pin_i = 1, lv_trip_i = 0, lv_detect_enable_i = 0, lv_reset_enable_i = 0;
   logic lv_stop_enable_i = 0, in_stop_i = 0, unimpl_opcode_i = 0, stop_instr_i = 0;
   logic bg_instruction_i = 0, bg_mode_enable_i = 0, clockgen_reset_req_i = 0, wdog_tick_i = 0;
   logic [7:0] rdata_o, cause_o;
   logic system_reset_o, stop_grant_o, rd_pend = 0;
   rcso_opt_s opt_o;
   logic [7:0] exp_q[$];
   int bad_count = 0, cmp_count = 0;
   int seed = 32'h7faf;

   always #2 clock_i = ~clock_i;

   rcso_host u_host (.clock_i, .req_o(req_i));

   // Short watchdog limits keep the timeout scenario brief
   rcso_top #(.WDOG_SHORT_BUS(16), .WDOG_LONG_BUS(32)) uut (.clock_i, .reset_i, .req_i,
      .reset_pin_i, .lv_trip_i, .lv_detect_enable_i, .lv_reset_enable_i, .lv_stop_enable_i,
      .in_stop_i, .unimpl_opcode_i, .stop_instr_i, .bg_instruction_i, .bg_mode_enable_i,
      .clockgen_reset_req_i, .wdog_tick_i, .rdata_o, .system_reset_o, .stop_grant_o, .opt_o,
      .cause_o);

   // ***********************************************
   // Tasks
   // ***********************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      cmp_count++;
      if (seen !== want) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic final_report();
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic rd(input rcso_sel_e sel, input logic [7:0] want);
      exp_q.push_back(want);
      u_host.access(1'b1, 1'b0, 1'b0, sel, 8'h00);
   endtask

   task automatic settle();
      int n;
      n = 0;
      while (system_reset_o !== 1'b0 && n < 300) begin
         @(negedge clock_i);
         n++;
      end
      check(8'(system_reset_o), 8'h00);
   endtask

   // Level sources are dropped once the reset starts, else the pin would retrigger
   task automatic fire(ref logic s, input logic act, input logic [7:0] want);
      int n;
      @(negedge clock_i);
      s = act;
      n = 0;
      while (system_reset_o !== 1'b1 && n < 300) begin
         @(negedge clock_i);
         n++;
      end
      s = ~act;
      settle();
      rd(RCSO_SEL_CAUSE, want);
   endtask

   // ***********************************************
   // Result monitor and run control
   // ***********************************************
   always @(posedge clock_i) rd_pend <= req_i.rd && !system_reset_o;

   always @(negedge clock_i) begin
      if (rd_pend) begin
         check(rdata_o, exp_q.pop_front());
      end
   end

   initial begin
      #20000;
      bad_count++;
      final_report();
   end

   initial begin
      repeat (10) @(negedge clock_i);
      reset_i = 0;
      settle();
      rd(RCSO_SEL_CAUSE, 8'h82);
      rd(RCSO_SEL_OPT1, 8'hc2);
      rd(RCSO_SEL_DBG, 8'h00);
      rd(RCSO_SEL_OPT2, 8'h80);
      u_host.access(1'b0, 1'b1, 1'b0, RCSO_SEL_CAUSE, 8'($random(seed)));
      rd(RCSO_SEL_CAUSE, 8'h82);
      lv_detect_enable_i = 1;
      lv_trip_i = 1;
      repeat (10) @(negedge clock_i);
      check(8'(system_reset_o), 8'h00);
      in_stop_i = 1;
      lv_reset_enable_i = 1;
      repeat (10) @(negedge clock_i);
      check(8'(system_reset_o), 8'h00);
      lv_stop_enable_i = 1;
      fire(lv_trip_i, 1'b1, 8'h82);
      u_host.access(1'b0, 1'b1, 1'b0, RCSO_SEL_OPT1, 8'h21);
      u_host.access(1'b0, 1'b1, 1'b0, RCSO_SEL_OPT1, 8'hc2);
      rd(RCSO_SEL_OPT1, 8'h21);
      @(negedge clock_i);
      stop_instr_i = 1;
      #1 check(8'(stop_grant_o), 8'h01);
      @(negedge clock_i);
      stop_instr_i = 0;
      u_host.access(1'b0, 1'b1, 1'b0, RCSO_SEL_DBG, 8'($random(seed)) | 8'h01);
      rd(RCSO_SEL_CAUSE, 8'h82);
      u_host.access(1'b0, 1'b1, 1'b1, RCSO_SEL_DBG, 8'h01);
      settle();
      rd(RCSO_SEL_CAUSE, 8'h00);
      rd(RCSO_SEL_OPT1, 8'hc3);
      fire(unimpl_opcode_i, 1'b1, 8'h10);
      fire(stop_instr_i, 1'b1, 8'h10);
      bg_mode_enable_i = 1;
      bg_instruction_i = 1;
      @(negedge clock_i);
      bg_instruction_i = 0;
      bg_mode_enable_i = 0;
      check(8'(system_reset_o), 8'h00);
      fire(bg_instruction_i, 1'b1, 8'h10);
      fire(clockgen_reset_req_i, 1'b1, 8'h04);
      fire(reset_pin_i, 1'b0, 8'h40);
      u_host.access(1'b0, 1'b1, 1'b0, RCSO_SEL_OPT2, 8'h00);
      u_host.access(1'b0, 1'b1, 1'b0, RCSO_SEL_OPT1, 8'h80);
      fire(idle, 1'b0, 8'h20);
      rd(RCSO_SEL_OPT2, 8'h80);
      check(8'(opt_o), 8'h37);
      @(negedge clock_i);
      reset_i = 1;
      repeat (10) @(negedge clock_i);
      reset_i = 0;
      settle();
      rd(RCSO_SEL_CAUSE, 8'h82);
      rd(RCSO_SEL_OPT1, 8'hc2);
      repeat (4) @(negedge clock_i);
      final_report();
   end
endmodule
